// ==== scdp_defs.vh ====
`ifndef SCDP_DEFS_VH
`define SCDP_DEFS_VH

// ********************************
// register byte offsets
// ********************************
`define SCDP_OFS_ROUTE   8'hA8
`define SCDP_OFS_PWRREQ  8'hAC
`define SCDP_OFS_PDIS    8'hB0
`define SCDP_OFS_SUSP    8'hB4
`define SCDP_OFS_PROT    8'hB8
`define SCDP_OFS_DMACTL  8'hE0
`define SCDP_OFS_STATUS  8'hE4

// ********************************
// reset values
// ********************************
`define SCDP_RST_ROUTE   32'h0000_0000
`define SCDP_RST_PDIS    32'h0000_0000
`define SCDP_RST_SUSP    32'h0000_0020
`define SCDP_RST_PROT    32'h0000_8001
`define SCDP_RST_DMACTL  32'h0000_0000

// ********************************
// writable bit masks
// ********************************
`define SCDP_MSK_ROUTE   32'h0005_FFFF
`define SCDP_MSK_PDIS    32'h0000_001F
`define SCDP_MSK_SUSP    32'h0000_003F
`define SCDP_MSK_PROT    32'h0100_C001
`define SCDP_MSK_DMACTL  32'h0000_FFFF

// ********************************
// field positions
// ********************************
`define SCDP_BIT_SLEEP    1
`define SCDP_BIT_STOP     2
`define SCDP_BIT_OTSLEEP  0
`define SCDP_BIT_OTWINH   14
`define SCDP_BIT_XWINH    15
`define SCDP_BIT_BRSD     24
`define SCDP_BIT_BUS0     16
`define SCDP_BIT_BUS1     18
`define SCDP_POS_S0RX     0
`define SCDP_POS_S0TX     2
`define SCDP_POS_S1RX     4
`define SCDP_POS_S1TX     6
`define SCDP_POS_A0RX     8
`define SCDP_POS_A0TX     10
`define SCDP_POS_A1RX     12
`define SCDP_POS_A1TX     14

// ********************************
// route codes
// ********************************
`define SCDP_CODE_LO     2'h1
`define SCDP_CODE_HI     2'h2

`endif

// ==== scdp_regs.v ====
`timescale 1ns/1ps
`include "scdp_defs.vh"

// Functional notes
// - sync0 rx, async0 tx: 01->ch1, 10->ch3
// - sync0 tx, async0 rx: 01->ch0, 10->ch2
// - sync1 rx, async1 tx: 01->ch5, 10->ch7
// - sync1 tx, async1 rx: 01->ch4, 10->ch6
// - bus message lines: bit16->ch0, bit18->ch1
// - sleep request bit self-clears, zero ignored
// - stop request bit self-clears
// - five disable bits switch peripherals off
// - six debug freeze bits, watchdog set
// - overheat sleep only when enabled
// - heat warning shutdown unless inhibited
// - crystal monitor shutdown unless inhibited
// - bridge off on any live shutdown when enabled
// - endless enables in bits 0..7
// - pending irq enables from bit 8
// - irq enables up to 15, upper reserved
module scdp_regs #(
  parameter NCH = 8
) (
  // clock and reset
  input  wire             mclk_i,
  input  wire             rst_b_i,
  // avalon-mm slave
  input  wire [7:0]       avs_address_i,
  input  wire             avs_read_i,
  input  wire             avs_write_i,
  input  wire [31:0]      avs_writedata_i,
  input  wire [3:0]       avs_byteenable_i,
  output reg  [31:0]      avs_readdata_o,
  output wire             avs_waitrequest_o,
  output reg  [1:0]       avs_response_o,
  // peripheral dma requests
  input  wire             sync0_rx_req_i,
  input  wire             sync0_tx_req_i,
  input  wire             sync1_rx_req_i,
  input  wire             sync1_tx_req_i,
  input  wire             async0_rx_req_i,
  input  wire             async0_tx_req_i,
  input  wire             async1_rx_req_i,
  input  wire             async1_tx_req_i,
  input  wire             bus_msg_line0_req_i,
  input  wire             bus_msg_line1_req_i,
  output reg  [NCH-1:0]   dma_req_o,
  // dma channel control
  input  wire [NCH-1:0]   dma_done_i,
  input  wire [NCH-1:0]   dma_pending_i,
  output reg  [NCH-1:0]   dma_reload_o,
  output wire [NCH-1:0]   dma_pending_irq_o,
  // power and protection
  input  wire             system_overheat_i,
  input  wire             heat_warning_i,
  input  wire             crystal_monitor_fail_i,
  input  wire             debug_halt_request_i,
  output reg              sleep_entry_o,
  output reg              stop_entry_o,
  output reg              periph_shutdown_o,
  output reg              bridge_driver_off_o,
  // peripheral management
  output wire             sync0_off_o,
  output wire             sync1_off_o,
  output wire             timer_a_off_o,
  output wire             timer_b_off_o,
  output wire             gp_timer_unit_off_o,
  output reg  [5:0]       freeze_o
);

  // ********************************
  // registers
  // ********************************
  reg  [31:0] route_q;
  reg  [31:0] pdis_q;
  reg  [31:0] susp_q;
  reg  [31:0] prot_q;
  reg  [31:0] dmactl_q;
  reg  [2:1]  pwrreq_q;
  reg         rd_done_q;
  reg  [31:0] rd_data_d;
  reg         rd_hit_d;
  wire [31:0] be_mask;
  wire        wr_en;
  wire        shut_live;
  integer     k;

  // 2-bit route decode, shared by all the serial fields
  function [NCH-1:0] scdp_route;
    input [1:0] code;
    input integer ch_lo;
    input integer ch_hi;
    begin
      scdp_route = {NCH{1'b0}};
      if (code == `SCDP_CODE_LO) begin
        scdp_route[ch_lo] = 1'b1;
      end else if (code == `SCDP_CODE_HI) begin
        scdp_route[ch_hi] = 1'b1;
      end
    end
  endfunction

  function [31:0] scdp_merge;
    input [31:0] old;
    input [31:0] wdat;
    input [31:0] bmask;
    input [31:0] wmask;
    begin
      scdp_merge = ((old & ~bmask) | (wdat & bmask)) & wmask;
    end
  endfunction

  // ********************************
  // bus slave
  // ********************************
  // writes land in one cycle; reads wait one cycle so data comes from a flop
  assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                    {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wr_en   = avs_write_i & ~avs_read_i;
  assign avs_waitrequest_o = avs_read_i & ~rd_done_q;

  always @* begin
    rd_hit_d  = 1'b1;
    rd_data_d = 32'h0000_0000;
    case (avs_address_i)
      `SCDP_OFS_ROUTE:  rd_data_d = route_q;
      `SCDP_OFS_PWRREQ: rd_data_d = 32'h0000_0000;
      `SCDP_OFS_PDIS:   rd_data_d = pdis_q;
      `SCDP_OFS_SUSP:   rd_data_d = susp_q;
      `SCDP_OFS_PROT:   rd_data_d = prot_q;
      `SCDP_OFS_DMACTL: rd_data_d = dmactl_q;
      `SCDP_OFS_STATUS: rd_data_d = {22'h0, periph_shutdown_o, bridge_driver_off_o,
                                     dma_pending_i};
      default:          rd_hit_d  = 1'b0;
    endcase
  end

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rd_done_q      <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= 2'h0;
    end else begin
      rd_done_q <= avs_read_i & ~rd_done_q;
      if (avs_read_i & ~rd_done_q) begin
        avs_readdata_o <= rd_data_d;
        avs_response_o <= rd_hit_d ? 2'h0 : 2'h3;
      end else if (wr_en) begin
        avs_response_o <= rd_hit_d ? 2'h0 : 2'h3;
      end
    end
  end

  // ********************************
  // register writes
  // ********************************
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      route_q  <= `SCDP_RST_ROUTE;
      pdis_q   <= `SCDP_RST_PDIS;
      susp_q   <= `SCDP_RST_SUSP;
      prot_q   <= `SCDP_RST_PROT;
      dmactl_q <= `SCDP_RST_DMACTL;
      pwrreq_q <= 2'b00;
    end else begin
      // request lasts one cycle then clears
      pwrreq_q <= 2'b00;
      if (wr_en) begin
        case (avs_address_i)
          `SCDP_OFS_ROUTE:
            route_q <= scdp_merge(route_q, avs_writedata_i, be_mask, `SCDP_MSK_ROUTE);
          `SCDP_OFS_PWRREQ: begin
            if (avs_byteenable_i[0]) begin
              pwrreq_q[1] <= avs_writedata_i[`SCDP_BIT_SLEEP];
              pwrreq_q[2] <= avs_writedata_i[`SCDP_BIT_STOP];
            end
          end
          `SCDP_OFS_PDIS:
            pdis_q <= scdp_merge(pdis_q, avs_writedata_i, be_mask, `SCDP_MSK_PDIS);
          `SCDP_OFS_SUSP:
            susp_q <= scdp_merge(susp_q, avs_writedata_i, be_mask, `SCDP_MSK_SUSP);
          `SCDP_OFS_PROT:
            prot_q <= scdp_merge(prot_q, avs_writedata_i, be_mask, `SCDP_MSK_PROT);
          `SCDP_OFS_DMACTL:
            dmactl_q <= scdp_merge(dmactl_q, avs_writedata_i, be_mask, `SCDP_MSK_DMACTL);
          default: ;
        endcase
      end
    end
  end

  // ********************************
  // dma request routing
  // ********************************
  always @* begin
    dma_req_o = {NCH{1'b0}};
    dma_req_o = dma_req_o
      | (scdp_route(route_q[`SCDP_POS_S0RX+:2], 1, 3) & {NCH{sync0_rx_req_i}})
      | (scdp_route(route_q[`SCDP_POS_A0TX+:2], 1, 3) & {NCH{async0_tx_req_i}});
    dma_req_o = dma_req_o
      | (scdp_route(route_q[`SCDP_POS_S0TX+:2], 0, 2) & {NCH{sync0_tx_req_i}})
      | (scdp_route(route_q[`SCDP_POS_A0RX+:2], 0, 2) & {NCH{async0_rx_req_i}});
    dma_req_o = dma_req_o
      | (scdp_route(route_q[`SCDP_POS_S1RX+:2], 5, 7) & {NCH{sync1_rx_req_i}})
      | (scdp_route(route_q[`SCDP_POS_A1TX+:2], 5, 7) & {NCH{async1_tx_req_i}});
    dma_req_o = dma_req_o
      | (scdp_route(route_q[`SCDP_POS_S1TX+:2], 4, 6) & {NCH{sync1_tx_req_i}})
      | (scdp_route(route_q[`SCDP_POS_A1RX+:2], 4, 6) & {NCH{async1_rx_req_i}});
    dma_req_o[0] = dma_req_o[0] | (route_q[`SCDP_BIT_BUS0] & bus_msg_line0_req_i);
    dma_req_o[1] = dma_req_o[1] | (route_q[`SCDP_BIT_BUS1] & bus_msg_line1_req_i);
  end

  // ********************************
  // dma channel control
  // ********************************
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_chan
      assign dma_pending_irq_o[g] = dmactl_q[NCH+g] & dma_pending_i[g];
    end
  endgenerate

  // reload is a registered pulse one cycle after the channel's done pulse
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      dma_reload_o <= {NCH{1'b0}};
    end else begin
      for (k = 0; k < NCH; k = k + 1) begin
        dma_reload_o[k] <= dmactl_q[k] & dma_done_i[k];
      end
    end
  end

  // ********************************
  // power and protection
  // ********************************
  // shutdown sources gated
  assign shut_live = (heat_warning_i & ~prot_q[`SCDP_BIT_OTWINH])
                   | (crystal_monitor_fail_i & ~prot_q[`SCDP_BIT_XWINH]);

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sleep_entry_o       <= 1'b0;
      stop_entry_o        <= 1'b0;
      periph_shutdown_o   <= 1'b0;
      bridge_driver_off_o <= 1'b0;
      freeze_o            <= 6'h00;
    end else begin
      sleep_entry_o <= pwrreq_q[1]
                     | (system_overheat_i & prot_q[`SCDP_BIT_OTSLEEP]);
      stop_entry_o      <= pwrreq_q[2];
      periph_shutdown_o <= shut_live;
      bridge_driver_off_o <= shut_live & prot_q[`SCDP_BIT_BRSD];
      freeze_o <= susp_q[5:0] & {6{debug_halt_request_i}};
    end
  end

  assign sync0_off_o         = pdis_q[0];
  assign sync1_off_o         = pdis_q[1];
  assign timer_a_off_o       = pdis_q[2];
  assign timer_b_off_o       = pdis_q[3];
  assign gp_timer_unit_off_o = pdis_q[4];

endmodule // scdp_regs

// ==== scdp_regs_checker.sv ====
`timescale 1ns/1ps
`include "scdp_defs.vh"
// ********************************
// port-level checks
// ********************************
module scdp_chk #(parameter NCH = 8) (
  // bus side
  input wire           mclk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o,
  input wire [7:0]     avs_address_i,
  input wire [31:0]    avs_writedata_i,
  input wire [3:0]     avs_byteenable_i,
  // dma, power and protection
  input wire [NCH-1:0] dma_done_i, dma_pending_i, dma_reload_o, dma_pending_irq_o,
  input wire           system_overheat_i, heat_warning_i, crystal_monitor_fail_i,
  input wire           debug_halt_request_i, sleep_entry_o, stop_entry_o,
  input wire           periph_shutdown_o, bridge_driver_off_o,
  input wire [5:0]     freeze_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // request bits sit in the low byte lane only
  wire pw  = avs_write_i && avs_address_i == `SCDP_OFS_PWRREQ && avs_byteenable_i[0];
  wire slp = pw && avs_writedata_i[1];
  wire stp = pw && avs_writedata_i[2];
  write_nowait_a: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  read_wait_a: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("read waited twice");
  sleep_req_a: assert property (slp |-> ##2 sleep_entry_o)
    else $error("sleep entry missing");
  sleep_cause_a: assert property (sleep_entry_o |-> $past(slp, 2) || $past(system_overheat_i))
    else $error("sleep entry without cause");
  stop_req_a: assert property (stp |-> ##2 stop_entry_o)
    else $error("stop entry missing");
  stop_clear_a: assert property (stop_entry_o |=> !stop_entry_o || $past(stp, 2))
    else $error("stop entry stuck");
  shut_cause_a: assert property (periph_shutdown_o |-> $past(heat_warning_i || crystal_monitor_fail_i))
    else $error("shutdown without event");
  bridge_sub_a: assert property (bridge_driver_off_o |-> periph_shutdown_o)
    else $error("bridge off without shutdown");
  irq_pend_a: assert property ((dma_pending_irq_o & ~dma_pending_i) == '0)
    else $error("irq without pending request");
  reload_cause_a: assert property ((dma_reload_o & ~$past(dma_done_i)) == '0)
    else $error("reload without completion");
  freeze_cause_a: assert property (|freeze_o |-> $past(debug_halt_request_i))
    else $error("freeze without halt");
endmodule // scdp_chk

bind scdp_regs scdp_chk #(.NCH(NCH)) chk_u (.*);

// ==== scdp_regs_test.sv ====
`timescale 1ns/1ps
module scdp_regs_test;
  logic mclk_i = 1'h0, rst_b_i = 1'h0, avs_read_i = 1'h0, avs_write_i = 1'h0;
  logic [7:0] avs_address_i = 8'h00, dma_done_i = 8'h00, dma_pending_i = 8'h00;
  logic [31:0] avs_writedata_i = 32'h0, rd;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [9:0] rq = 10'h000;
  logic [2:0] ev = 3'h0;
  logic debug_halt_request_i = 1'h0;
  logic [1:0] rs;
  wire system_overheat_i, heat_warning_i, crystal_monitor_fail_i;
  wire sync0_rx_req_i, sync0_tx_req_i, sync1_rx_req_i, sync1_tx_req_i, async0_rx_req_i;
  wire async0_tx_req_i, async1_rx_req_i, async1_tx_req_i;
  wire bus_msg_line0_req_i, bus_msg_line1_req_i, avs_waitrequest_o;
  wire [31:0] avs_readdata_o;
  wire [1:0] avs_response_o;
  wire [7:0] dma_req_o, dma_reload_o, dma_pending_irq_o;
  wire sleep_entry_o, stop_entry_o, periph_shutdown_o, bridge_driver_off_o;
  wire sync0_off_o, sync1_off_o, timer_a_off_o, timer_b_off_o, gp_timer_unit_off_o;
  wire [5:0] freeze_o;
  int miscompares = 0, check_count = 0;
  assign {bus_msg_line1_req_i, bus_msg_line0_req_i, async1_tx_req_i, async1_rx_req_i,
          async0_tx_req_i, async0_rx_req_i, sync1_tx_req_i, sync1_rx_req_i,
          sync0_tx_req_i, sync0_rx_req_i} = rq;
  assign {system_overheat_i, heat_warning_i, crystal_monitor_fail_i} = ev;
  scdp_regs dut_u (.*);
  always #20 mclk_i = ~mclk_i;
  // ********************************
  // shared tasks
  // ********************************
  task automatic cmp(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // waitrequest is looked at mid-cycle, once settled; the request stands to the
  // next rising edge, where the answer is taken and only then dropped
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ws;
    @(posedge mclk_i);
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(negedge mclk_i);
      ws = avs_waitrequest_o;
      @(posedge mclk_i);
    end while (ws !== 1'h0);
    rd = avs_readdata_o;
    rs = avs_response_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_regs;
    logic [7:0] ofs [6] = '{8'hA8, 8'hAC, 8'hB0, 8'hB4, 8'hB8, 8'hE0};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h20, 32'h8001, 32'h0};
    logic [31:0] mk [6] = '{32'h5FFFF, 32'h0, 32'h1F, 32'h3F, 32'h100C001, 32'hFFFF};
    for (int i = 0; i < 6; i++) begin
      bus(1'h0, ofs[i], 32'h0);
      cmp("reset value", rv[i], rd);
      bus(1'h1, ofs[i], 32'hFFFFFFFF);
      bus(1'h0, ofs[i], 32'h0);
      cmp("masked readback", mk[i], rd);
      if (i == 2) cmp("off outputs", 32'h1F, {gp_timer_unit_off_o, timer_b_off_o,
        timer_a_off_o, sync1_off_o, sync0_off_o});
      bus(1'h1, ofs[i], rv[i]);
    end
    cmp("off outputs", 32'h0, {gp_timer_unit_off_o, timer_b_off_o, timer_a_off_o,
      sync1_off_o, sync0_off_o});
    bus(1'h0, 8'h10, 32'h0);
    cmp("unmapped data", 32'h0, rd);
    cmp("unmapped response", 32'h3, rs);
    $display("registers test done");
  endtask
  task automatic t_route;
    int lo [8] = '{1, 0, 5, 4, 0, 1, 4, 5};
    logic [7:0] e;
    for (int f = 0; f < 8; f++)
      for (int c = 0; c < 4; c++) begin
        bus(1'h1, 8'hA8, c << (2 * f));
        rq <= 10'h1 << f;
        e = c == 1 ? 8'h1 << lo[f] : c == 2 ? 8'h4 << lo[f] : 8'h00;
        @(negedge mclk_i);
        cmp("routed request", e, dma_req_o);
      end
    bus(1'h1, 8'hA8, 32'h50000);
    rq <= 10'h100;
    @(negedge mclk_i);
    cmp("message line 0", 32'h1, dma_req_o);
    @(posedge mclk_i);
    rq <= 10'h200;
    @(negedge mclk_i);
    cmp("message line 1", 32'h2, dma_req_o);
    bus(1'h1, 8'hA8, 32'h0);
    rq <= 10'h000;
    $display("routing test done");
  endtask
  task automatic t_power;
    for (int b = 0; b < 3; b++) begin
      bus(1'h1, 8'hAC, b * 2);
      for (int n = 1; n < 4; n++) begin
        @(negedge mclk_i);
        cmp("power pulses", n == 2 ? b : 0, {stop_entry_o, sleep_entry_o});
      end
    end
    $display("power test done");
  endtask
  task automatic t_prot;
    logic [31:0] cf [7] = '{32'h0, 32'h1000000, 32'h1004000, 32'h1004000,
                            32'h100C000, 32'h0, 32'h1};
    logic [2:0] ei [7] = '{3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h4, 3'h4};
    logic [2:0] ex [7] = '{3'h2, 3'h3, 3'h0, 3'h3, 3'h0, 3'h0, 3'h4};
    for (int i = 0; i < 7; i++) begin
      bus(1'h1, 8'hB8, cf[i]);
      ev <= ei[i];
      repeat (2) @(negedge mclk_i);
      cmp("protection", ex[i], {sleep_entry_o, periph_shutdown_o,
        bridge_driver_off_o});
      @(posedge mclk_i);
      ev <= 3'h0;
    end
    bus(1'h1, 8'hB8, 32'h8001);
    bus(1'h1, 8'hB4, 32'h15);
    debug_halt_request_i <= 1'h1;
    repeat (2) @(negedge mclk_i);
    cmp("freeze", 32'h15, freeze_o);
    @(posedge mclk_i);
    debug_halt_request_i <= 1'h0;
    repeat (2) @(negedge mclk_i);
    cmp("freeze", 32'h0, freeze_o);
    bus(1'h1, 8'hB4, 32'h20);
    $display("protection test done");
  endtask
  task automatic t_dma;
    bus(1'h1, 8'hE0, 32'h5AA5);
    dma_pending_i <= 8'hFF;
    dma_done_i <= 8'hFF;
    @(negedge mclk_i);
    cmp("pending irq", 32'h5A, dma_pending_irq_o);
    @(posedge mclk_i);
    dma_done_i <= 8'h00;
    dma_pending_i <= 8'h00;
    @(negedge mclk_i);
    cmp("reload", 32'hA5, dma_reload_o);
    @(negedge mclk_i);
    cmp("reload", 32'h0, dma_reload_o);
    @(posedge mclk_i);
    dma_pending_i <= 8'h3C;
    bus(1'h0, 8'hE4, 32'h0);
    cmp("status", 32'h3C, rd);
    dma_pending_i <= 8'h00;
    bus(1'h1, 8'hE0, 32'h0);
    $display("dma test done");
  endtask
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'h1;
    t_regs();
    t_route();
    t_power();
    t_prot();
    t_dma();
    final_report();
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    miscompares++;
    final_report();
  end
endmodule // scdp_regs_test
